/* ebh_pkg.sv */
// How it works
// - In the hold state the grant acknowledge is low and the bus lines are released.
// - The grant acknowledge is forced high for as long as reset is applied.
// - A low float input puts all four status outputs into high impedance.
// - With two or more wait states programmed, wait-done goes low during the last one.
// - Wait-done looped to ready adds exactly one external wait after the internal ones.
// - The fetch flag is low only in bus cycles that carry an instruction address.
// - The machine clock rises at the start of every machine cycle.
// - A hold request, once acknowledged, releases address, data and control lines.
// - Ready is sampled only after the wait states, only with two or more, and retried.
package ebh_pkg;
	// ****************************************
	// Sizes and timing
	// ****************************************
	localparam int unsigned MC_DIV_DEF = 6;
	// Ready path latency through the pin filter needs this many sys clocks per cycle
	localparam int unsigned MC_DIV_MIN = 6;
	localparam int unsigned WS_W       = 3;
	localparam logic [WS_W-1:0] WS_ZERO    = 3'h0;
	localparam logic [WS_W-1:0] WS_ONE     = 3'h1;
	localparam logic [WS_W-1:0] WS_EXT_MIN = 3'h2;
	// ****************************************
	// Pin filter layout and reset levels
	// ****************************************
	localparam int unsigned PIN_N     = 3;
	localparam int unsigned PIN_HOLD  = 0;
	localparam int unsigned PIN_FLOAT = 1;
	localparam int unsigned PIN_READY = 2;
	localparam logic [PIN_N-1:0] PIN_RST = 3'h7;
	typedef enum logic [2:0] {
		EBH_IDLE,
		EBH_HOLD,
		EBH_ACCESS,
		EBH_SWWAIT,
		EBH_EXTWAIT
	} ebh_state_t;
endpackage

/* ebh_pin_if.sv */
`timescale 1ns/1ps
interface ebh_pin_if #(
	parameter int unsigned N = 3
);
	logic [N-1:0] raw;
	logic [N-1:0] clean;
	modport filt (input raw, output clean);
	modport core (output raw, input clean);
endinterface

/* ebh_pin_sync.sv */
`timescale 1ns/1ps
module ebh_pin_sync #(
	parameter int unsigned        N       = 3,
	parameter logic [N-1:0]       RST_VAL = '1
) (
	input  wire logic i_clk_sys,
	input  wire logic i_rst_b,
	ebh_pin_if.filt   pins
);
	logic [N-1:0] s1_q;
	logic [N-1:0] s2_q;
	logic [N-1:0] s3_q;
	logic [N-1:0] clean_q;

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= pins.raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Accept a level only once two stages agree
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			clean_q <= RST_VAL;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					clean_q[i] <= s2_q[i];
				end
			end
		end
	end

	assign pins.clean = clean_q;
endmodule

/* ebh_top.sv */
`timescale 1ns/1ps
module ebh_top #(
	parameter int unsigned MC_DIV = ebh_pkg::MC_DIV_DEF
) (
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_rst_b,
	input  wire logic                     i_hold_req_n,
	input  wire logic                     i_float_n,
	input  wire logic                     i_ready,
	input  wire logic                     i_acc_start,
	input  wire logic                     i_acc_is_instr,
	input  wire logic [ebh_pkg::WS_W-1:0] i_acc_wait_states,
	output logic                          o_bus_grant_ack_n,
	output logic                          o_bus_grant_ack_oe_n,
	output logic                          o_wait_states_done_n,
	output logic                          o_wait_states_done_oe_n,
	output logic                          o_instr_fetch_flag_n,
	output logic                          o_instr_fetch_flag_oe_n,
	output logic                          o_machine_cycle_clock_out,
	output logic                          o_machine_cycle_clock_oe_n,
	output logic                          o_bus_lines_oe_n,
	output logic                          o_acc_busy,
	output logic                          o_acc_done
);
	// ****************************************
	// Elaboration checks
	// ****************************************
	if (MC_DIV < ebh_pkg::MC_DIV_MIN) begin : g_div_check
		$error("MC_DIV too small for the ready pin filter");
	end

	localparam int unsigned CNT_W = $clog2(MC_DIV);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(MC_DIV - 1);
	localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(MC_DIV / 2);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;

	// ****************************************
	// Pin filtering
	// ****************************************
	ebh_pin_if #(.N(ebh_pkg::PIN_N)) pins ();
	assign pins.raw[ebh_pkg::PIN_HOLD]  = i_hold_req_n;
	assign pins.raw[ebh_pkg::PIN_FLOAT] = i_float_n;
	assign pins.raw[ebh_pkg::PIN_READY] = i_ready;

	ebh_pin_sync #(
		.N       (ebh_pkg::PIN_N),
		.RST_VAL (ebh_pkg::PIN_RST)
	) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.pins      (pins)
	);

	logic hold_req;
	logic floated;
	logic ready;
	assign hold_req = !pins.clean[ebh_pkg::PIN_HOLD];
	assign floated  = !pins.clean[ebh_pkg::PIN_FLOAT];
	assign ready    = pins.clean[ebh_pkg::PIN_READY];

	// ****************************************
	// Machine cycle timing
	// ****************************************
	logic [CNT_W-1:0] cnt_q;
	logic             tick;
	assign tick = (cnt_q == CNT_LAST);

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_q <= CNT_ZERO;
		end else if (tick) begin
			cnt_q <= CNT_ZERO;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// High in the first half, so each cycle opens on a rising edge
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_machine_cycle_clock_out <= 1'b1;
		end else begin
			o_machine_cycle_clock_out <= tick || (cnt_q < CNT_HALF - 1'b1);
		end
	end

	// ****************************************
	// Access request capture
	// ****************************************
	logic                     pend_q;
	logic                     instr_q;
	logic [ebh_pkg::WS_W-1:0] ws_q;
	logic [ebh_pkg::WS_W-1:0] ws_left_q;
	ebh_pkg::ebh_state_t      state_q;
	logic                     start_acc;
	logic                     finish;

	assign start_acc = tick && (state_q == ebh_pkg::EBH_IDLE) && pend_q && !hold_req;

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pend_q  <= 1'b0;
			instr_q <= 1'b0;
			ws_q    <= ebh_pkg::WS_ZERO;
		end else if (i_acc_start && !o_acc_busy) begin
			pend_q  <= 1'b1;
			instr_q <= i_acc_is_instr;
			ws_q    <= i_acc_wait_states;
		end else if (start_acc) begin
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_acc_busy <= 1'b0;
		end else if (i_acc_start && !o_acc_busy) begin
			o_acc_busy <= 1'b1;
		end else if (finish) begin
			o_acc_busy <= 1'b0;
		end
	end

	// ****************************************
	// Bus cycle sequencer
	// ****************************************
	always_comb begin
		finish = 1'b0;
		if (tick) begin
			case (state_q)
				ebh_pkg::EBH_ACCESS:  finish = (ws_q == ebh_pkg::WS_ZERO);
				ebh_pkg::EBH_SWWAIT:  finish = (ws_left_q == ebh_pkg::WS_ONE) &&
					((ws_q < ebh_pkg::WS_EXT_MIN) || ready);
				ebh_pkg::EBH_EXTWAIT: finish = ready;
				default:              finish = 1'b0;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q   <= ebh_pkg::EBH_IDLE;
			ws_left_q <= ebh_pkg::WS_ZERO;
		end else if (tick) begin
			case (state_q)
				ebh_pkg::EBH_IDLE: begin
					if (hold_req) begin
						state_q <= ebh_pkg::EBH_HOLD;
					end else if (pend_q) begin
						state_q <= ebh_pkg::EBH_ACCESS;
					end
				end
				ebh_pkg::EBH_HOLD: begin
					// Back to idle first, so the bus is driven again before access
					if (!hold_req) begin
						state_q <= ebh_pkg::EBH_IDLE;
					end
				end
				ebh_pkg::EBH_ACCESS: begin
					if (finish) begin
						state_q <= ebh_pkg::EBH_IDLE;
					end else begin
						state_q   <= ebh_pkg::EBH_SWWAIT;
						ws_left_q <= ws_q;
					end
				end
				ebh_pkg::EBH_SWWAIT: begin
					if (ws_left_q != ebh_pkg::WS_ONE) begin
						ws_left_q <= ws_left_q - 1'b1;
					end else if (finish) begin
						state_q <= ebh_pkg::EBH_IDLE;
					end else begin
						state_q <= ebh_pkg::EBH_EXTWAIT;
					end
				end
				ebh_pkg::EBH_EXTWAIT: begin
					// Not ready: one more cycle, then look again
					if (finish) begin
						state_q <= ebh_pkg::EBH_IDLE;
					end
				end
				default: state_q <= ebh_pkg::EBH_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_acc_done <= 1'b0;
		end else begin
			o_acc_done <= finish;
		end
	end

	// ****************************************
	// Status pins
	// ****************************************
	ebh_pkg::ebh_state_t state_d;
	logic                last_sw_d;
	always_comb begin
		state_d   = state_q;
		last_sw_d = 1'b0;
		if (tick) begin
			if (state_q == ebh_pkg::EBH_IDLE && hold_req) begin
				state_d = ebh_pkg::EBH_HOLD;
			end else if (state_q == ebh_pkg::EBH_HOLD && !hold_req) begin
				state_d = ebh_pkg::EBH_IDLE;
			end else if (start_acc) begin
				state_d = ebh_pkg::EBH_ACCESS;
			end else if (finish) begin
				state_d = ebh_pkg::EBH_IDLE;
			end else if (state_q == ebh_pkg::EBH_ACCESS) begin
				state_d   = ebh_pkg::EBH_SWWAIT;
				last_sw_d = (ws_q == ebh_pkg::WS_ONE);
			end else if (state_q == ebh_pkg::EBH_SWWAIT) begin
				state_d   = (ws_left_q == ebh_pkg::WS_ONE) ? ebh_pkg::EBH_EXTWAIT : state_q;
				last_sw_d = (ws_left_q == ebh_pkg::WS_EXT_MIN);
			end
		end else begin
			last_sw_d = (state_q == ebh_pkg::EBH_SWWAIT) && (ws_left_q == ebh_pkg::WS_ONE);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_bus_grant_ack_n    <= 1'b1;
			o_wait_states_done_n <= 1'b1;
			o_instr_fetch_flag_n <= 1'b1;
			o_bus_lines_oe_n     <= 1'b0;
		end else begin
			o_bus_grant_ack_n    <= (state_d != ebh_pkg::EBH_HOLD);
			o_wait_states_done_n <= !(last_sw_d && (ws_q >= ebh_pkg::WS_EXT_MIN));
			o_instr_fetch_flag_n <= !(instr_q && (state_d == ebh_pkg::EBH_ACCESS ||
				state_d == ebh_pkg::EBH_SWWAIT || state_d == ebh_pkg::EBH_EXTWAIT));
			o_bus_lines_oe_n     <= (state_d == ebh_pkg::EBH_HOLD) || floated;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_bus_grant_ack_oe_n       <= 1'b0;
			o_wait_states_done_oe_n    <= 1'b0;
			o_instr_fetch_flag_oe_n    <= 1'b0;
			o_machine_cycle_clock_oe_n <= 1'b0;
		end else begin
			o_bus_grant_ack_oe_n       <= floated;
			o_wait_states_done_oe_n    <= floated;
			o_instr_fetch_flag_oe_n    <= floated;
			o_machine_cycle_clock_oe_n <= floated;
		end
	end
endmodule

/* ebh_checker.sv */
`timescale 1ns/1ps
module ebh_checker #(
	parameter int MC_DIV = 6
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_float_n,
	input wire logic o_bus_grant_ack_n,
	input wire logic o_bus_grant_ack_oe_n,
	input wire logic o_wait_states_done_n,
	input wire logic o_wait_states_done_oe_n,
	input wire logic o_instr_fetch_flag_n,
	input wire logic o_instr_fetch_flag_oe_n,
	input wire logic o_machine_cycle_clock_out,
	input wire logic o_machine_cycle_clock_oe_n,
	input wire logic o_bus_lines_oe_n,
	input wire logic o_acc_done
);
	// ****
	// Pin relations
	// ****
	logic oe_all;
	logic oe_any;
	assign oe_all = o_bus_grant_ack_oe_n & o_wait_states_done_oe_n
		& o_instr_fetch_flag_oe_n & o_machine_cycle_clock_oe_n;
	assign oe_any = o_bus_grant_ack_oe_n | o_wait_states_done_oe_n
		| o_instr_fetch_flag_oe_n | o_machine_cycle_clock_oe_n;
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_b);
	property p_hold_rel;
		!o_bus_grant_ack_n && !o_bus_grant_ack_oe_n |-> o_bus_lines_oe_n;
	endproperty
	a_hold_rel: assert property (p_hold_rel) else $error("bus driven in hold");
	property p_float_z;
		$fell(i_float_n) |-> ##[1:8] oe_all;
	endproperty
	a_float_z: assert property (p_float_z) else $error("float too slow");
	property p_float_on;
		i_float_n [*8] |-> !oe_any;
	endproperty
	a_float_on: assert property (p_float_on) else $error("pins not driven");
	property p_mclk_per;
		$rose(o_machine_cycle_clock_out) |-> ##MC_DIV $rose(o_machine_cycle_clock_out);
	endproperty
	a_mclk_per: assert property (p_mclk_per) else $error("mclk period");
	property p_mclk_hi;
		$rose(o_machine_cycle_clock_out) |->
			o_machine_cycle_clock_out [*3] ##1 !o_machine_cycle_clock_out;
	endproperty
	a_mclk_hi: assert property (p_mclk_hi) else $error("mclk high time");
	property p_done_len;
		$fell(o_wait_states_done_n) |-> (!o_wait_states_done_n) [*6] ##1 o_wait_states_done_n;
	endproperty
	a_done_len: assert property (p_done_len) else $error("wait done length");
	property p_fetch_bus;
		!o_instr_fetch_flag_n && !o_instr_fetch_flag_oe_n |-> !o_bus_lines_oe_n;
	endproperty
	a_fetch_bus: assert property (p_fetch_bus) else $error("fetch on idle bus");
	property p_no_acc_hold;
		!o_bus_grant_ack_n |-> !o_acc_done;
	endproperty
	a_no_acc_hold: assert property (p_no_acc_hold) else $error("access in hold");
endmodule

/* ebh_far_model.sv */
`timescale 1ns/1ps
module ebh_far_model (
	input  wire logic       i_clk_sys,
	input  wire logic [1:0] i_mode,
	input  wire logic       i_want_bus,
	input  wire logic       i_wait_done_n,
	input  wire logic       i_wait_done_oe_n,
	output logic            o_ready,
	output logic            o_hold_req_n
);
	// ****
	// Memory and outside master
	// ****
	logic [3:0] cnt_q = 4'h0;
	logic       prev_q = 1'h1;
	logic       up;
	// Pull-up keeps ready high while the pin floats
	assign up = i_wait_done_oe_n | i_wait_done_n;
	always_ff @(posedge i_clk_sys) begin
		prev_q <= i_wait_done_n;
		if (!i_wait_done_n && prev_q) begin
			cnt_q <= 4'hb;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
	// Mode 0 loops wait-done, 1 is slow, 2 holds ready low
	assign o_ready = (i_mode == 2'h2) ? 1'h0 : (i_mode == 2'h1) ? (up && cnt_q == 4'h0) : up;
	assign o_hold_req_n = !i_want_bus;
endmodule

/* ebh_top_tb.sv */
`timescale 1ns/1ps
module ebh_top_tb;
	// ****
	// Stimulus and checks
	// ****
	logic       clk   = 1'h0;
	logic       rst_b = 1'h0;
	logic       want  = 1'h0;
	logic       fl_n  = 1'h1;
	logic       start = 1'h0;
	logic       instr = 1'h0;
	logic [2:0] ws    = 3'h0;
	logic [1:0] mode  = 2'h0;
	logic       rdy, hreq_n, ack_n, ack_oe_n, dn_n, dn_oe_n, fq_n, fq_oe_n;
	logic       mclk, mclk_oe_n, bus_oe_n, done, busy;
	int         mismatches = 0;
	int         samples_checked = 0;
	ebh_top i_ebh_top (
		.i_clk_sys(clk), .i_rst_b(rst_b), .i_hold_req_n(hreq_n), .i_float_n(fl_n),
		.i_ready(rdy), .i_acc_start(start), .i_acc_is_instr(instr),
		.i_acc_wait_states(ws), .o_bus_grant_ack_n(ack_n), .o_bus_grant_ack_oe_n(ack_oe_n),
		.o_wait_states_done_n(dn_n), .o_wait_states_done_oe_n(dn_oe_n),
		.o_instr_fetch_flag_n(fq_n), .o_instr_fetch_flag_oe_n(fq_oe_n),
		.o_machine_cycle_clock_out(mclk), .o_machine_cycle_clock_oe_n(mclk_oe_n),
		.o_bus_lines_oe_n(bus_oe_n), .o_acc_busy(busy), .o_acc_done(done)
	);
	ebh_far_model i_ebh_far_model (
		.i_clk_sys(clk), .i_mode(mode), .i_want_bus(want), .i_wait_done_n(dn_n),
		.i_wait_done_oe_n(dn_oe_n), .o_ready(rdy), .o_hold_req_n(hreq_n)
	);
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmpn(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, lo);
		end
	endtask
	task automatic tk(input int k);
		repeat (k) @(posedge clk);
	endtask
	// Start is aligned to a machine clock rise so the length is exact
	task automatic acc(input logic ins, input logic [2:0] w, input logic [1:0] m, input int cyc);
		int   n;
		logic sf;
		logic sd;
		logic sb;
		n = 0;
		sf = 1'h1;
		sd = 1'h1;
		sb = 1'h1;
		mode <= m;
		tk(1);
		while (mclk !== 1'h0) tk(1);
		while (mclk !== 1'h1) tk(1);
		start <= 1'h1;
		instr <= ins;
		ws <= w;
		while (done !== 1'h1 && n < 200) begin
			tk(1);
			start <= 1'h0;
			n++;
			sf &= fq_n;
			sd &= dn_n;
			if (n > 1 && done !== 1'h1) sb &= busy;
		end
		cmpn(n, 6 * cyc + 6, 6 * cyc + 8);
		cmp(sb, 1'h1);
		cmp(busy, 1'h0);
		cmp(sf, !ins);
		cmp(sd, w < 3'h2);
	endtask
	task automatic hold_scn;
		int n;
		n = 0;
		want <= 1'h1;
		while (ack_n !== 1'h0 && n < 40) begin
			tk(1);
			n++;
		end
		cmpn(n, 1, 39);
		cmp(bus_oe_n, 1'h1);
		start <= 1'h1;
		ws <= 3'h0;
		tk(1);
		start <= 1'h0;
		tk(10);
		// Busy with the held access: this request must be dropped
		start <= 1'h1;
		ws <= 3'h7;
		tk(1);
		start <= 1'h0;
		tk(19);
		cmp(ack_n, 1'h0);
		cmp(busy, 1'h1);
		want <= 1'h0;
		n = 0;
		while (done !== 1'h1 && n < 60) begin
			tk(1);
			n++;
		end
		cmp(ack_n, 1'h1);
		cmp(bus_oe_n, 1'h0);
		cmpn(n, 12, 59);
	endtask
	task automatic float_scn;
		fl_n <= 1'h0;
		tk(12);
		cmp(ack_oe_n & dn_oe_n & fq_oe_n & mclk_oe_n, 1'h1);
		fl_n <= 1'h1;
		tk(12);
		cmp(ack_oe_n | dn_oe_n | fq_oe_n | mclk_oe_n, 1'h0);
	endtask
	task automatic rst_scn;
		want <= 1'h1;
		tk(30);
		cmp(ack_n, 1'h0);
		rst_b <= 1'h0;
		tk(2);
		cmp(ack_n, 1'h1);
		rst_b <= 1'h1;
		want <= 1'h0;
		tk(12);
	endtask
	initial begin
		tk(15);
		cmp(ack_n, 1'h1);
		tk(1);
		rst_b <= 1'h1;
		for (int w = 0; w < 8; w++) begin
			acc(w[0], w[2:0], 2'h0, 1 + w + (w >= 2 ? 1 : 0));
		end
		acc(1'h0, 3'h1, 2'h2, 2);
		acc(1'h1, 3'h0, 2'h2, 1);
		acc(1'h1, 3'h2, 2'h1, 5);
		hold_scn();
		float_scn();
		rst_scn();
		finish_test();
	end
	// Whole run needs well under this span
	initial begin
		#1000000;
		mismatches++;
		finish_test();
	end
endmodule
bind ebh_top ebh_checker #(.MC_DIV(MC_DIV)) i_ebh_checker (
	.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_float_n(i_float_n),
	.o_bus_grant_ack_n(o_bus_grant_ack_n), .o_bus_grant_ack_oe_n(o_bus_grant_ack_oe_n),
	.o_wait_states_done_n(o_wait_states_done_n),
	.o_wait_states_done_oe_n(o_wait_states_done_oe_n),
	.o_instr_fetch_flag_n(o_instr_fetch_flag_n),
	.o_instr_fetch_flag_oe_n(o_instr_fetch_flag_oe_n),
	.o_machine_cycle_clock_out(o_machine_cycle_clock_out),
	.o_machine_cycle_clock_oe_n(o_machine_cycle_clock_oe_n),
	.o_bus_lines_oe_n(o_bus_lines_oe_n), .o_acc_done(o_acc_done)
);
